// ---- logic/irq_expander_defines.vh ----
// constants for the interrupt expander and external interrupt channels
`ifndef IRQ_EXPANDER_DEFINES_VH
`define IRQ_EXPANDER_DEFINES_VH
`define SRC_COUNT 96
`define SRC_USED 43
`define GROUP_SIZE 8
`define GROUP_COUNT 12
`define VEC_WIDTH 32
`define IDX_WIDTH 7
`define FETCH_CYCLES 4'd8
`define STAMP_WIDTH 16
`define GPIO_A_WIDTH 32
`define CHAN_A_SRC 7'd3
`define CHAN_B_SRC 7'd4
`define POL_FALLING 2'b00
`define POL_RISING 2'b01
`define POL_BOTH 2'b10
`define ADDR_CTRL 12'h000
`define ADDR_INT_STATUS 12'h004
`define ADDR_INT_MASK 12'h008
`define ADDR_ENABLE0 12'h010
`define ADDR_ENABLE1 12'h014
`define ADDR_ENABLE2 12'h018
`define ADDR_PENDING0 12'h020
`define ADDR_PENDING1 12'h024
`define ADDR_PENDING2 12'h028
`define ADDR_EXT_CFG0 12'h030
`define ADDR_EXT_CFG1 12'h034
`define ADDR_EXT_CFG2 12'h038
`define ADDR_EXT_STAMP0 12'h040
`define ADDR_EXT_STAMP1 12'h044
`define ADDR_EXT_STAMP2 12'h048
`define ADDR_VEC_BASE 3'b001
`define CTRL_NMI_ROUTE 0
`define CFG_EN 0
`define CFG_POL_LSB 1
`define CFG_SEL_LSB 4
`define CTRL_RESET 1'b0
`define CFG_RESET 9'h000
`endif

// ---- logic/vector_ram.v ----
// per-source vector storage, one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_defines.vh"
module vector_ram (
  input wire mclk,
  input wire we,
  input wire [`IDX_WIDTH-1:0] waddr,
  input wire [`VEC_WIDTH-1:0] wdata,
  input wire [`IDX_WIDTH-1:0] raddr,
  output reg [`VEC_WIDTH-1:0] rdata
);
  reg [`VEC_WIDTH-1:0] mem [0:`SRC_COUNT-1];
  // no reset: contents are software's to load
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- logic/ext_irq_chan.v ----
// one external interrupt channel: edge detect plus timestamp counter
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_defines.vh"
module ext_irq_chan (
  input wire mclk,
  input wire resetn,
  input wire pin,
  input wire enable,
  input wire [1:0] polarity,
  output reg edge_r,
  output reg [`STAMP_WIDTH-1:0] stamp_r
);
  reg pin_prev_r;
  wire rise = pin & ~pin_prev_r;
  wire fall = ~pin & pin_prev_r;
  reg hit;
  always @* begin
    case (polarity)
      `POL_FALLING: hit = fall;
      `POL_RISING: hit = rise;
      default: hit = rise | fall;
    endcase
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_r <= 1'b0;
      edge_r <= 1'b0;
      stamp_r <= {`STAMP_WIDTH{1'b0}};
    end else begin
      pin_prev_r <= pin;
      edge_r <= hit & enable;
      if (hit & enable) begin
        stamp_r <= {`STAMP_WIDTH{1'b0}};
      end else begin
        stamp_r <= stamp_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/irq_expander.v ----
// grouped peripheral interrupt expander with three external channels
// Behaviour
// - accept 96 request inputs, 43 used
// - eight per group onto twelve cpu lines
// - each source has writable vector RAM entry
// - vector delivered eight cycles after acknowledge
// - separate enable for every single source
// - fixed order within group plus enable masks
// - three external channels: two general, one nonmaskable
// - falling, rising or both edge selection
// - per-channel enable blocks disabled channel requests
// - nonmaskable channel routes to line thirteen or nmi
// - 16-bit stamp counter cleared on valid edge
// - channel input picked from any port A pin
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_defines.vh"
module irq_expander (
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`SRC_COUNT-1:0] periph_irq,
  input wire [`GPIO_A_WIDTH-1:0] gpio_a,
  output reg [`GROUP_COUNT-1:0] cpu_irq_line,
  output reg cpu_irq_line_thirteen,
  output reg cpu_nmi,
  input wire cpu_ack,
  input wire [3:0] cpu_ack_line,
  output reg [`VEC_WIDTH-1:0] cpu_vector,
  output reg cpu_vector_valid,
  output reg irq
);
  // lowest set bit of a group wins; hit says any was set
  function [3:0] first_set;
    input [7:0] v;
    integer k;
    begin
      first_set = 4'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  // register slots, decoded once and shared by the read and write paths
  localparam SLOT_CTRL = 4'd0;
  localparam SLOT_STATUS = 4'd1;
  localparam SLOT_MASK = 4'd2;
  localparam SLOT_EN0 = 4'd3;
  localparam SLOT_EN1 = 4'd4;
  localparam SLOT_EN2 = 4'd5;
  localparam SLOT_PEND0 = 4'd6;
  localparam SLOT_PEND1 = 4'd7;
  localparam SLOT_PEND2 = 4'd8;
  localparam SLOT_CFG0 = 4'd9;
  localparam SLOT_CFG1 = 4'd10;
  localparam SLOT_CFG2 = 4'd11;
  localparam SLOT_STAMP0 = 4'd12;
  localparam SLOT_STAMP1 = 4'd13;
  localparam SLOT_STAMP2 = 4'd14;
  localparam SLOT_NONE = 4'd15;

  function [3:0] reg_slot;
    input [11:0] a;
    begin
      case (a)
        `ADDR_CTRL: reg_slot = SLOT_CTRL;
        `ADDR_INT_STATUS: reg_slot = SLOT_STATUS;
        `ADDR_INT_MASK: reg_slot = SLOT_MASK;
        `ADDR_ENABLE0: reg_slot = SLOT_EN0;
        `ADDR_ENABLE1: reg_slot = SLOT_EN1;
        `ADDR_ENABLE2: reg_slot = SLOT_EN2;
        `ADDR_PENDING0: reg_slot = SLOT_PEND0;
        `ADDR_PENDING1: reg_slot = SLOT_PEND1;
        `ADDR_PENDING2: reg_slot = SLOT_PEND2;
        `ADDR_EXT_CFG0: reg_slot = SLOT_CFG0;
        `ADDR_EXT_CFG1: reg_slot = SLOT_CFG1;
        `ADDR_EXT_CFG2: reg_slot = SLOT_CFG2;
        `ADDR_EXT_STAMP0: reg_slot = SLOT_STAMP0;
        `ADDR_EXT_STAMP1: reg_slot = SLOT_STAMP1;
        `ADDR_EXT_STAMP2: reg_slot = SLOT_STAMP2;
        default: reg_slot = SLOT_NONE;
      endcase
    end
  endfunction

  reg ctrl_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg [`SRC_COUNT-1:0] enable_r;
  reg [`SRC_COUNT-1:0] pending_r;
  reg [8:0] cfg_r [0:2];
  wire [2:0] chan_edge;
  wire [`STAMP_WIDTH-1:0] stamp [0:2];

  // external channels
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : chan
      wire sel_pin = gpio_a[cfg_r[c][`CFG_SEL_LSB +: 5]];
      ext_irq_chan u_chan (
        .mclk(mclk),
        .resetn(resetn),
        .pin(sel_pin),
        .enable(cfg_r[c][`CFG_EN]),
        .polarity(cfg_r[c][`CFG_POL_LSB +: 2]),
        .edge_r(chan_edge[c]),
        .stamp_r(stamp[c])
      );
    end
  endgenerate

  // apb decode
  wire acc = psel & penable;
  wire in_vec = (paddr[11:9] == `ADDR_VEC_BASE) && (paddr[8:2] < `SRC_COUNT);
  wire wr_now = acc & pready & pwrite;
  wire [3:0] slot = reg_slot(paddr);
  reg apb_ram_wait_r;
  reg known;
  reg [31:0] rd_val;
  always @* begin
    known = 1'b1;
    rd_val = 32'h0000_0000;
    case (slot)
      SLOT_CTRL: rd_val = {31'h0000_0000, ctrl_r};
      SLOT_STATUS: rd_val = {29'h0000_0000, status_r};
      SLOT_MASK: rd_val = {29'h0000_0000, mask_r};
      SLOT_EN0: rd_val = enable_r[31:0];
      SLOT_EN1: rd_val = enable_r[63:32];
      SLOT_EN2: rd_val = enable_r[95:64];
      SLOT_PEND0: rd_val = pending_r[31:0];
      SLOT_PEND1: rd_val = pending_r[63:32];
      SLOT_PEND2: rd_val = pending_r[95:64];
      SLOT_CFG0: rd_val = {23'h00_0000, cfg_r[0]};
      SLOT_CFG1: rd_val = {23'h00_0000, cfg_r[1]};
      SLOT_CFG2: rd_val = {23'h00_0000, cfg_r[2]};
      SLOT_STAMP0: rd_val = {16'h0000, stamp[0]};
      SLOT_STAMP1: rd_val = {16'h0000, stamp[1]};
      SLOT_STAMP2: rd_val = {16'h0000, stamp[2]};
      default: known = in_vec;
    endcase
  end

  // acknowledge and vector fetch
  wire ack_ok = cpu_ack && (cpu_ack_line >= 4'd1) && (cpu_ack_line <= 4'd12);
  wire [3:0] grp = cpu_ack_line - 4'd1;
  wire [7:0] grp_req = pending_r[{grp, 3'b000} +: 8] & enable_r[{grp, 3'b000} +: 8];
  wire [3:0] win = first_set(grp_req);
  wire [`IDX_WIDTH-1:0] win_idx = {grp[3:0], win[2:0]};
  localparam F_IDLE = 2'd0;
  localparam F_LOAD = 2'd1;
  localparam F_COUNT = 2'd2;
  reg [1:0] fstate_r;
  reg [3:0] fcnt_r;
  reg hit_r;
  reg [`VEC_WIDTH-1:0] vec_hold_r;
  wire take_ack = ack_ok & (fstate_r == F_IDLE);
  // fetch owns the read port; an apb vector read simply retries
  wire apb_ram_issue = acc & ~pready & in_vec & ~pwrite & ~apb_ram_wait_r & ~take_ack;
  wire [`IDX_WIDTH-1:0] ram_raddr = take_ack ? win_idx : paddr[8:2];
  wire [`VEC_WIDTH-1:0] ram_q;

  vector_ram u_ram (
    .mclk(mclk),
    .we(wr_now & in_vec),
    .waddr(paddr[8:2]),
    .wdata(pwdata),
    .raddr(ram_raddr),
    .rdata(ram_q)
  );

  // pending flags: a request in the clearing cycle is kept
  reg [`SRC_COUNT-1:0] pend_set;
  reg [`SRC_COUNT-1:0] pend_clr;
  always @* begin
    pend_set = periph_irq;
    pend_set[`CHAN_A_SRC] = periph_irq[`CHAN_A_SRC] | chan_edge[0];
    pend_set[`CHAN_B_SRC] = periph_irq[`CHAN_B_SRC] | chan_edge[1];
    pend_clr = {`SRC_COUNT{1'b0}};
    if (take_ack & win[3]) begin
      pend_clr[win_idx] = 1'b1;
    end
  end

  // one cpu line per group of eight; the line trails pending by a cycle
  wire [`GROUP_COUNT-1:0] grp_any;
  genvar g;
  generate
    for (g = 0; g < `GROUP_COUNT; g = g + 1) begin : grp_or
      assign grp_any[g] = |(pending_r[g*8 +: 8] & enable_r[g*8 +: 8]);
    end
  endgenerate

  // set beats a write-one clear in the same cycle
  wire [2:0] status_nxt = (status_r & ~(wr_now && slot == SLOT_STATUS ? pwdata[2:0] : 3'b000))
    | chan_edge;
  integer i;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RESET;
      status_r <= 3'b000;
      mask_r <= 3'b000;
      enable_r <= {`SRC_COUNT{1'b0}};
      pending_r <= {`SRC_COUNT{1'b0}};
      for (i = 0; i < 3; i = i + 1) begin
        cfg_r[i] <= `CFG_RESET;
      end
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      apb_ram_wait_r <= 1'b0;
      cpu_irq_line <= {`GROUP_COUNT{1'b0}};
      cpu_irq_line_thirteen <= 1'b0;
      cpu_nmi <= 1'b0;
      fstate_r <= F_IDLE;
      fcnt_r <= 4'h0;
      hit_r <= 1'b0;
      vec_hold_r <= {`VEC_WIDTH{1'b0}};
      cpu_vector <= {`VEC_WIDTH{1'b0}};
      cpu_vector_valid <= 1'b0;
      irq <= 1'b0;
    end else begin
      pending_r <= (pending_r & ~pend_clr) | pend_set;
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
      cpu_irq_line <= grp_any;
      cpu_irq_line_thirteen <= chan_edge[2] & ~ctrl_r;
      cpu_nmi <= chan_edge[2] & ctrl_r;
      // apb: one wait cycle for registers and vector writes, two or more for vector reads
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (acc & ~pready) begin
        if (apb_ram_wait_r) begin
          apb_ram_wait_r <= 1'b0;
          prdata <= ram_q;
          pready <= 1'b1;
        end else if (apb_ram_issue) begin
          apb_ram_wait_r <= 1'b1;
        end else if (~(in_vec & ~pwrite)) begin
          prdata <= pwrite ? 32'h0000_0000 : rd_val;
          pslverr <= ~known;
          pready <= 1'b1;
        end
      end
      if (wr_now) begin
        case (slot)
          SLOT_CTRL: ctrl_r <= pwdata[`CTRL_NMI_ROUTE];
          SLOT_MASK: mask_r <= pwdata[2:0];
          SLOT_EN0: enable_r[31:0] <= pwdata;
          SLOT_EN1: enable_r[63:32] <= pwdata;
          SLOT_EN2: enable_r[95:64] <= pwdata;
          SLOT_CFG0: cfg_r[0] <= pwdata[8:0];
          SLOT_CFG1: cfg_r[1] <= pwdata[8:0];
          SLOT_CFG2: cfg_r[2] <= pwdata[8:0];
          default: ;
        endcase
      end
      // vector fetch plus context save takes a fixed count
      cpu_vector_valid <= 1'b0;
      case (fstate_r)
        F_IDLE: begin
          if (take_ack) begin
            fstate_r <= F_LOAD;
            fcnt_r <= 4'h1;
            hit_r <= win[3];
          end
        end
        F_LOAD: begin
          // the winner's ram word stands on the read port now
          vec_hold_r <= hit_r ? ram_q : {`VEC_WIDTH{1'b0}};
          fcnt_r <= fcnt_r + 4'h1;
          fstate_r <= F_COUNT;
        end
        F_COUNT: begin
          // context save is plain waiting here, no bus traffic
          fcnt_r <= fcnt_r + 4'h1;
          if (fcnt_r == `FETCH_CYCLES - 4'h1) begin
            fstate_r <= F_IDLE;
            cpu_vector <= vec_hold_r;
            cpu_vector_valid <= 1'b1;
          end
        end
        default: fstate_r <= F_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/irq_expander_monitor.sv ----
// port assertions for the interrupt expander
`timescale 1ns/1ps
`default_nettype none
module irq_expander_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_ack,
  input wire logic cpu_nmi,
  input wire logic cpu_irq_line_thirteen,
  input wire logic cpu_vector_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  vec_latency_a: assert property (cpu_vector_valid |-> $past(cpu_ack, 8))
    else $error("vector late");
  vec_spacing_a: assert property (cpu_vector_valid |=> !cpu_vector_valid [*7])
    else $error("vector too soon");
  route_excl_a: assert property (!(cpu_nmi && cpu_irq_line_thirteen))
    else $error("both routes");
  nmi_pulse_a: assert property (cpu_nmi |=> !cpu_nmi)
    else $error("nmi long");
  line_pulse_a: assert property (cpu_irq_line_thirteen |=> !cpu_irq_line_thirteen)
    else $error("line long");
  ready_wait_a: assert property (psel && !penable |=> !pready)
    else $error("no wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("stray error");
endmodule
bind irq_expander irq_expander_monitor mon (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack),
  .cpu_nmi(cpu_nmi), .cpu_irq_line_thirteen(cpu_irq_line_thirteen),
  .cpu_vector_valid(cpu_vector_valid));
`default_nettype wire

// ---- verif/cpu_core_model.sv ----
// processor side: acks the lowest raised line, then waits for its vector
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hold,
  input wire logic [11:0] cpu_irq_line,
  input wire logic cpu_vector_valid,
  output logic cpu_ack,
  output logic [3:0] cpu_ack_line
);
  logic busy;
  logic [3:0] pick;
  always @* begin
    pick = 4'h0;
    for (int k = 11; k >= 0; k--)
      if (cpu_irq_line[k]) pick = 4'(k + 1);
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack <= 1'b0;
      cpu_ack_line <= 4'hf;
      busy <= 1'b0;
    end else begin
      // hold lets the bench look at the lines before service
      cpu_ack <= !busy && !hold && pick != 4'h0;
      cpu_ack_line <= busy ? 4'hf : pick;
      busy <= busy ? !cpu_vector_valid : !hold && pick != 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/test_irq_expander.sv ----
// randomised bench for the interrupt expander
`timescale 1ns/1ps
`default_nettype none
`include "irq_expander_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module test_irq_expander;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b1;
  logic pready, pslverr, err, cpu_irq_line_thirteen, cpu_nmi, cpu_ack, cpu_vector_valid, irq;
  logic [11:0] paddr = 12'h000;
  logic [11:0] cpu_irq_line;
  logic [3:0] cpu_ack_line;
  logic [31:0] pwdata = 32'h0, gpio_a = 32'h0, prdata, rd, s1, cpu_vector, got_vec;
  logic [95:0] periph_irq = 96'h0;
  int n_fail = 0, n_checks = 0, cyc = 0, n_vec = 0, n_nmi = 0, n_l13 = 0, seed = 74, i, j, p;
  irq_expander dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_irq(periph_irq), .gpio_a(gpio_a), .cpu_irq_line(cpu_irq_line),
    .cpu_irq_line_thirteen(cpu_irq_line_thirteen), .cpu_nmi(cpu_nmi), .cpu_ack(cpu_ack),
    .cpu_ack_line(cpu_ack_line), .cpu_vector(cpu_vector), .irq(irq),
    .cpu_vector_valid(cpu_vector_valid));
  cpu_core_model cpu (.mclk(mclk), .resetn(resetn), .hold(hold), .cpu_irq_line(cpu_irq_line),
    .cpu_vector_valid(cpu_vector_valid), .cpu_ack(cpu_ack), .cpu_ack_line(cpu_ack_line));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    n_nmi += (cpu_nmi === 1'b1);
    n_l13 += (cpu_irq_line_thirteen === 1'b1);
    if (cpu_vector_valid === 1'b1) begin
      got_vec = cpu_vector;
      n_vec++;
    end
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic get(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic pin(input logic val);
    @(posedge mclk);
    gpio_a[p] <= val;
    repeat (6) @(posedge mclk);
  endtask
  task automatic wait_vec(input int n);
    for (int k = 0; k < 40 && n_vec < n; k++) @(posedge mclk);
  endtask
  function automatic logic ex(input int pol, input int up);
    return up ? pol != 0 : pol != 1;
  endfunction
  function automatic logic [11:0] va(input int s);
    return 12'h200 + 12'(4 * s);
  endfunction
  function automatic logic [11:0] ea(input int s);
    return `ADDR_ENABLE0 + 12'(4 * (s / 32));
  endfunction
  // request arrives while masked, then enable releases it
  task automatic src(input int s);
    logic [31:0] v;
    v = $random(seed);
    wr(va(s), v);
    get(va(s));
    `CHK(rd, v)
    @(posedge mclk);
    periph_irq[s] <= 1'b1;
    @(posedge mclk);
    periph_irq[s] <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(cpu_irq_line, 12'h000)
    wr(ea(s), 32'h1 << (s % 32));
    repeat (3) @(posedge mclk);
    `CHK(cpu_irq_line, 12'h001 << (s / `GROUP_SIZE))
    hold <= 1'b0;
    wait_vec(n_vec + 1);
    hold <= 1'b1;
    `CHK(got_vec, v)
    wr(ea(s), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    gpio_a <= $random(seed);
    get(`ADDR_EXT_CFG2);
    `CHK(rd, 32'h0)
    get(12'h0fc);
    `CHK(err, 1'b1)
    for (i = 0; i < 6; i++)
      src(i < 2 ? i * 95 : $unsigned($random(seed)) % 96);
    wr(va(17), 32'ha1);
    wr(va(22), 32'hb2);
    wr(ea(17), 32'h0042_0000);
    @(posedge mclk);
    periph_irq <= 96'h0042_0000;
    @(posedge mclk);
    periph_irq <= 96'h0;
    hold <= 1'b0;
    wait_vec(n_vec + 1);
    `CHK(got_vec, 32'ha1)
    wait_vec(n_vec + 1);
    `CHK(got_vec, 32'hb2)
    hold <= 1'b1;
    wr(ea(17), 32'h0);
    p = $unsigned($random(seed)) % 32;
    pin(1'b0);
    wr(`ADDR_INT_MASK, 32'h1);
    for (i = 0; i < 3; i++)
      for (j = 1; j >= 0; j--) begin
        wr(`ADDR_EXT_CFG0, (p << 4) | (i << 1) | 1);
        wr(`ADDR_INT_STATUS, 32'h7);
        pin(j[0]);
        `CHK(irq, ex(i, j))
        get(`ADDR_INT_STATUS);
        `CHK(rd[0], ex(i, j))
      end
    wr(`ADDR_EXT_CFG0, (p << 4) | 4);
    wr(`ADDR_INT_STATUS, 32'h7);
    pin(1'b1);
    get(`ADDR_INT_STATUS);
    `CHK(rd[0], 1'b0)
    wr(`ADDR_EXT_CFG0, (p << 4) | 5);
    pin(1'b0);
    get(`ADDR_EXT_STAMP0);
    `CHK(rd[15:0] < 16'h0010, 1'b1)
    s1 = rd;
    get(`ADDR_EXT_STAMP0);
    `CHK(rd[15:0] - s1[15:0], 16'h0004)
    wr(`ADDR_INT_MASK, 32'h0);
    // move the selection while disabled, so the switch is not an edge
    wr(`ADDR_EXT_CFG2, p << 4);
    wr(`ADDR_EXT_CFG2, (p << 4) | 5);
    wr(`ADDR_CTRL, 32'h1);
    pin(1'b1);
    `CHK(irq, 1'b0)
    wr(`ADDR_CTRL, 32'h0);
    pin(1'b0);
    `CHK(n_nmi, 1)
    `CHK(n_l13, 1)
    summarize();
  end
endmodule
`default_nettype wire
